// *** verilog/iopm_pkg.sv ***
// Constants for the port mode selector: pin layout, masks, host kinds.
// Assumes seven byte ports A..G packed low to high, port D four pins.
//
// Functional notes
// - Control bit 0 on ports E, F, G selects host I/O mode.
// - Host mode drives the data-out value; inputs readable through read path.
// - A, B, C, F drivers enable on direction bit OR output-enable term.
// - Ports A, B, C default to host mode unless configured as logic pins.
// - Logic mode feeds input macrocells and drives macrocell outputs, tri-stated.
// - Latched address drives when control bit set and either direction bit or, on F only, enable term.
// - Multiplexed hosts: E, F carry a7-a0; G carries a15-a8.
// - Burst hosts: E, F low nibbles carry no address output.
// - Upper address lines feed logic inputs, optionally latched by strobe.
// - Inputs used in chip-select decode count as address inputs.
// - Peripheral mode only on port F, needs enable bit and selects.
// - Serial test-port pins exist only on port E, shared.
// - Per-port availability of macrocell, chip-select and logic inputs.
// - Ports F and G form the data bus for non-multiplexed hosts.
// - Reset pattern only on F, G, only for the 16-bit family.
// - Logic, data, address-in, reset-pattern modes are fixed; peripheral mode is set at run time.
// - Peripheral enable is bit 7 of the memory mapping control register.
// - Peripheral buffer tri-stated unless a peripheral select is active during a bus write.
// - Reset pattern driven during reset with no bus cycle.
// - All control and direction registers reset to zero.

package iopm_pkg;

    localparam int NPORT = 7;
    localparam int NPIN  = 56;

    // Port bases within the packed pin vector
    localparam int BASE_E = 32;
    localparam int BASE_F = 40;
    localparam int BASE_G = 48;

    // Ports G F E D C B A, high to low
    localparam logic [55:0] WIDTH_MASK =
        {8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
    localparam logic [55:0] LA_OUT_OK  =
        {8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
    localparam logic [55:0] OE_PT_OK   =
        {8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
    localparam logic [55:0] LA_IN_OK   =
        {8'h00, 8'hff, 8'h00, 8'h0f, 8'hff, 8'hff, 8'hff};
    // Address-capable bits of E, F, G (G high, E low)
    localparam logic [23:0] ADDR_MUX_OK   = 24'hffffff;
    localparam logic [23:0] ADDR_BURST_OK = 24'hfff0f0;

    // Host register kinds
    localparam logic [1:0] KIND_PIN  = 2'h0;
    localparam logic [1:0] KIND_DOUT = 2'h1;
    localparam logic [1:0] KIND_DIR  = 2'h2;
    localparam logic [1:0] KIND_CTRL = 2'h3;
    localparam logic [2:0] SEL_E     = 3'h4;
    localparam logic [2:0] SEL_MMAP  = 3'h7;
    localparam int         PIO_BIT   = 7;
    localparam logic [7:0] REG_RST   = 8'h00;

    // Test-port pins within port E
    localparam int TP_CLK_BIT = 0;
    localparam int TP_SEL_BIT = 1;
    localparam int TP_DIN_BIT = 2;
    localparam int TP_OUT_BIT = 3;

endpackage : iopm_pkg

// *** verilog/iopm_port_mux.sv ***
// Per-pin mode selection for ports A..G with host registers as plain ports.
// Assumes config inputs are static and captured while NRST is low.

`timescale 1ns/1ps

module iopm_port_mux
(
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    input  wire logic        CLK_EN,
    input  wire logic        REG_WR,
    input  wire logic [2:0]  REG_SEL,
    input  wire logic [1:0]  REG_KIND,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    input  wire logic [55:0] PIN_I,
    output logic      [55:0] PIN_O,
    output logic      [55:0] PIN_OE,
    input  wire logic [55:0] CFG_LA_OUT,
    input  wire logic [55:0] CFG_LA_IN,
    input  wire logic [55:0] CFG_IN_LATCH,
    input  wire logic [55:0] CFG_DECODE_USE,
    input  wire logic        CFG_NONMUX,
    input  wire logic        CFG_BURST,
    input  wire logic        CFG_RSTPAT_EN,
    input  wire logic        CFG_FAMILY16,
    input  wire logic [15:0] CFG_PATTERN,
    input  wire logic [55:0] LA_OUT_DATA,
    input  wire logic [55:0] LA_OE_PT,
    output logic      [55:0] LA_IN_BUS,
    output logic      [55:0] ADDR_IN_FLAGS,
    input  wire logic [15:0] ADDR_PINS,
    input  wire logic        STROBE_PIN,
    input  wire logic        HOST_RESET_PIN,
    input  wire logic        BUS_RD,
    input  wire logic        BUS_WR,
    input  wire logic [15:0] BUS_RDATA,
    output logic      [15:0] PORT_FG_IN,
    input  wire logic        PSEL_A,
    input  wire logic        PSEL_B,
    input  wire logic [7:0]  PERI_WDATA,
    input  wire logic        JTAG_EN,
    input  wire logic        TP_OUT,
    output logic      [2:0]  TP_IN
);

    // ************************************************************
    // Registers and synchronisers
    // ************************************************************
    logic [7:0]  dout_q [iopm_pkg::NPORT];
    logic [7:0]  dir_q  [iopm_pkg::NPORT];
    logic [7:0]  ctrl_q [3];
    logic [7:0]  mmap_q;
    logic [55:0] pin_s1_q, pin_s2_q;
    logic [15:0] adr_s1_q, adr_s2_q, addr_q;
    logic        stb_s1_q, stb_s2_q, stb_s3_q;
    logic        hrst_s1_q, hrst_s2_q;
    logic [55:0] cfg_la_out_q, cfg_la_in_q, cfg_latch_q, cfg_dec_q;
    logic        cfg_nonmux_q, cfg_burst_q, cfg_rstpat_q, cfg_fam_q;
    logic [15:0] cfg_pat_q;

    logic [55:0] dout_vec, dir_vec;
    logic [23:0] ctrl_vec;

    genvar gp;
    generate
        for (gp = 0; gp < iopm_pkg::NPORT; gp++)
        begin : g_flat
            assign dout_vec[gp*8 +: 8] = dout_q[gp];
            assign dir_vec[gp*8 +: 8]  = dir_q[gp];
        end
    endgenerate
    assign ctrl_vec = {ctrl_q[2], ctrl_q[1], ctrl_q[0]};

    // ************************************************************
    // Host write decode
    // ************************************************************
    wire       sel_ok  = REG_SEL < 3'(iopm_pkg::NPORT);
    wire [7:0] wmask   = iopm_pkg::WIDTH_MASK[REG_SEL*8 +: 8];
    wire       wr_dout = REG_WR && sel_ok
                         && REG_KIND == iopm_pkg::KIND_DOUT;
    wire       wr_dir  = REG_WR && sel_ok
                         && REG_KIND == iopm_pkg::KIND_DIR;
    wire       wr_ctrl = REG_WR && REG_KIND == iopm_pkg::KIND_CTRL
                         && REG_SEL >= iopm_pkg::SEL_E && sel_ok;
    wire       wr_mmap = REG_WR && REG_KIND == iopm_pkg::KIND_CTRL
                         && REG_SEL == iopm_pkg::SEL_MMAP;
    wire [1:0] ctrl_ix = 2'(REG_SEL - iopm_pkg::SEL_E);

    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            for (int i = 0; i < iopm_pkg::NPORT; i++)
            begin
                dout_q[i] <= iopm_pkg::REG_RST;
                dir_q[i]  <= iopm_pkg::REG_RST;
            end
            for (int i = 0; i < 3; i++)
                ctrl_q[i] <= iopm_pkg::REG_RST;
            mmap_q <= iopm_pkg::REG_RST;
        end
        else if (CLK_EN)
        begin
            if (wr_dout)
                dout_q[REG_SEL] <= REG_WDATA & wmask;
            if (wr_dir)
                dir_q[REG_SEL] <= REG_WDATA & wmask;
            if (wr_ctrl)
                ctrl_q[ctrl_ix] <= REG_WDATA;
            if (wr_mmap)
                mmap_q <= REG_WDATA;
        end
    end

    // Config is frozen at reset so run-time writes cannot alter it
    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            cfg_la_out_q <= CFG_LA_OUT;
            cfg_la_in_q  <= CFG_LA_IN;
            cfg_latch_q  <= CFG_IN_LATCH;
            cfg_dec_q    <= CFG_DECODE_USE;
            cfg_nonmux_q <= CFG_NONMUX;
            cfg_burst_q  <= CFG_BURST;
            cfg_rstpat_q <= CFG_RSTPAT_EN;
            cfg_fam_q    <= CFG_FAMILY16;
            cfg_pat_q    <= CFG_PATTERN;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            pin_s1_q  <= '0;
            pin_s2_q  <= '0;
            adr_s1_q  <= '0;
            adr_s2_q  <= '0;
            stb_s1_q  <= 1'b0;
            stb_s2_q  <= 1'b0;
            stb_s3_q  <= 1'b0;
            hrst_s1_q <= 1'b0;
            hrst_s2_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            pin_s1_q  <= PIN_I;
            pin_s2_q  <= pin_s1_q;
            adr_s1_q  <= ADDR_PINS;
            adr_s2_q  <= adr_s1_q;
            stb_s1_q  <= STROBE_PIN;
            stb_s2_q  <= stb_s1_q;
            stb_s3_q  <= stb_s2_q;
            hrst_s1_q <= HOST_RESET_PIN;
            hrst_s2_q <= hrst_s1_q;
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire        stb_rise  = stb_s2_q && !stb_s3_q;
    wire [55:0] la_sel    = cfg_la_out_q & iopm_pkg::LA_OUT_OK;
    wire [55:0] oe_pt     = LA_OE_PT & iopm_pkg::OE_PT_OK;
    wire [23:0] addr_ok   = cfg_burst_q ? iopm_pkg::ADDR_BURST_OK
                                        : iopm_pkg::ADDR_MUX_OK;
    wire [23:0] addr_sel  = ctrl_vec & addr_ok & ~{24{cfg_nonmux_q}};
    // E and F carry a7-a0, G carries a15-a8
    wire [23:0] addr_vec  = {addr_q[15:8], addr_q[7:0], addr_q[7:0]};
    wire [55:0] addr_sel_w = {addr_sel, 32'h0};
    wire [55:0] addr_w    = {addr_vec, 32'h0};
    wire        pio_act   = mmap_q[iopm_pkg::PIO_BIT];
    wire        psel_any  = PSEL_A || PSEL_B;
    wire        rst_drive = cfg_rstpat_q && cfg_fam_q && hrst_s2_q
                            && !BUS_RD && !BUS_WR;

    // Base path: address out, then logic output, then host data
    wire [55:0] base_o  = (addr_sel_w & addr_w)
                        | (~addr_sel_w & la_sel & LA_OUT_DATA)
                        | (~addr_sel_w & ~la_sel & dout_vec);
    wire [55:0] base_oe = (dir_vec | oe_pt) & iopm_pkg::WIDTH_MASK;

    logic [55:0] pin_o_d, pin_oe_d;
    always_comb
    begin
        pin_o_d  = base_o;
        pin_oe_d = base_oe;
        if (rst_drive)
        begin
            pin_o_d[55:40]  = cfg_pat_q;
            pin_oe_d[55:40] = 16'hffff;
        end
        else if (pio_act)
        begin
            pin_o_d[47:40]  = PERI_WDATA;
            pin_oe_d[47:40] = {8{psel_any && BUS_WR}};
            if (cfg_nonmux_q)
            begin
                pin_o_d[55:48]  = BUS_RDATA[15:8];
                pin_oe_d[55:48] = {8{BUS_RD}};
            end
        end
        else if (cfg_nonmux_q)
        begin
            pin_o_d[55:40]  = BUS_RDATA;
            pin_oe_d[55:40] = {16{BUS_RD}};
        end
        // Test port borrows low E pins; only used outside normal operation
        if (JTAG_EN)
        begin
            pin_oe_d[iopm_pkg::BASE_E +: 3] = 3'h0;
            pin_o_d[iopm_pkg::BASE_E + iopm_pkg::TP_OUT_BIT]  = TP_OUT;
            pin_oe_d[iopm_pkg::BASE_E + iopm_pkg::TP_OUT_BIT] = 1'b1;
        end
    end

    // Latched inputs hold between strobes, direct ones follow the pin
    wire [55:0] hold_m  = cfg_latch_q & {56{!stb_rise}};
    wire [55:0] la_in_d = ((hold_m & LA_IN_BUS) | (~hold_m & pin_s2_q))
                          & cfg_la_in_q & iopm_pkg::LA_IN_OK;

    logic [7:0] rd_d;
    always_comb
    begin
        rd_d = 8'h00;
        if (REG_SEL == iopm_pkg::SEL_MMAP && REG_KIND == iopm_pkg::KIND_CTRL)
            rd_d = mmap_q;
        else if (sel_ok)
        begin
            case (REG_KIND)
                iopm_pkg::KIND_PIN:  rd_d = pin_s2_q[REG_SEL*8 +: 8] & wmask;
                iopm_pkg::KIND_DOUT: rd_d = dout_q[REG_SEL];
                iopm_pkg::KIND_DIR:  rd_d = dir_q[REG_SEL];
                iopm_pkg::KIND_CTRL:
                    rd_d = (REG_SEL >= iopm_pkg::SEL_E) ? ctrl_q[ctrl_ix] : 8'h00;
                default:             rd_d = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (!NRST)
        begin
            PIN_O         <= '0;
            PIN_OE        <= '0;
            REG_RDATA     <= 8'h00;
            LA_IN_BUS     <= '0;
            ADDR_IN_FLAGS <= '0;
            PORT_FG_IN    <= 16'h0000;
            TP_IN         <= 3'h0;
            addr_q        <= 16'h0000;
        end
        else if (CLK_EN)
        begin
            PIN_O         <= pin_o_d;
            PIN_OE        <= pin_oe_d;
            REG_RDATA     <= rd_d;
            LA_IN_BUS     <= la_in_d;
            ADDR_IN_FLAGS <= cfg_dec_q & iopm_pkg::LA_IN_OK;
            PORT_FG_IN    <= pin_s2_q[55:40];
            TP_IN         <= JTAG_EN ? pin_s2_q[34:32] : 3'h0;
            if (stb_rise)
                addr_q <= adr_s2_q;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_dir_out;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && dir_vec[0] |=> PIN_OE[0];
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("dir set, no drive");

    property p_input;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && !dir_vec[8] && !LA_OE_PT[8] |=> !PIN_OE[8];
    endproperty
    a_input: assert property (p_input) else $error("input pin driven");

    property p_host_data;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && !cfg_la_out_q[1] |=> PIN_O[1] == $past(dout_vec[1]);
    endproperty
    a_host_data: assert property (p_host_data) else $error("bad host data");

    property p_rst_zero;
        @(posedge CORE_CLK) disable iff (!NRST)
        !$past(NRST) |-> dir_vec == 56'h0 && ctrl_vec == 24'h0 && mmap_q == 8'h00;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("regs not zero");

    property p_burst;
        @(posedge CORE_CLK) disable iff (!NRST)
        cfg_burst_q |-> addr_sel[3:0] == 4'h0 && addr_sel[11:8] == 4'h0;
    endproperty
    a_burst: assert property (p_burst) else $error("burst low nibble addr");

    property p_addr_g;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && addr_sel[16] && !rst_drive && !pio_act
        |=> PIN_O[48] == $past(addr_q[8]);
    endproperty
    a_addr_g: assert property (p_addr_g) else $error("bad G address bit");

    property p_pio_tri;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && pio_act && !psel_any && !rst_drive |=> PIN_OE[47:40] == 8'h00;
    endproperty
    a_pio_tri: assert property (p_pio_tri) else $error("port F not tri");

    property p_rstpat;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && rst_drive && !JTAG_EN
        |=> PIN_OE[55:40] == 16'hffff && PIN_O[55:40] == $past(cfg_pat_q);
    endproperty
    a_rstpat: assert property (p_rstpat) else $error("no reset pattern");

    property p_jtag;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && JTAG_EN |=> PIN_OE[34:32] == 3'h0 ##1 TP_IN == $past(pin_s2_q[34:32]) || !CLK_EN || !JTAG_EN;
    endproperty
    a_jtag: assert property (p_jtag) else $error("test pins driven");

    property p_strobe;
        @(posedge CORE_CLK) disable iff (!NRST)
        CLK_EN && stb_rise |=> addr_q == $past(adr_s2_q);
    endproperty
    a_strobe: assert property (p_strobe) else $error("address not latched");

    c_rstpat: cover property (@(posedge CORE_CLK) disable iff (!NRST) rst_drive);
    c_pio: cover property (@(posedge CORE_CLK) disable iff (!NRST)
        pio_act && psel_any && BUS_WR);
    c_addr: cover property (@(posedge CORE_CLK) disable iff (!NRST)
        addr_sel != 24'h0 && stb_rise);

endmodule : iopm_port_mux

// *** bench/iopm_pin_model.sv ***
// Pin-side model: resolves every port pin from both drivers.
// Assumes the bench sets ext_oe/ext_val; undriven pins toggle.

`timescale 1ns/1ps

module iopm_pin_model
(
    input  wire logic        clk,
    input  wire logic [55:0] pin_o,
    input  wire logic [55:0] pin_oe,
    input  wire logic [55:0] ext_oe,
    input  wire logic [55:0] ext_val,
    output logic      [55:0] pin_i
);
    // ***************
    // Pin resolution
    // ***************
    logic [55:0] float_q = 56'h0;

    // Floating pins change every cycle so a stale level never passes
    always @(posedge clk)
    begin
        float_q <= ~float_q;
    end

    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val)
                 | (~pin_oe & ~ext_oe & float_q);
endmodule : iopm_pin_model

// *** bench/iopm_port_mux_bench.sv ***
// Bench for the port mode selector: host register tasks and pin checks.
// Assumes iopm_pkg and the pin model are compiled first.

`timescale 1ns/1ps

module iopm_port_mux_bench;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic        reg_wr = 1'h0;
    logic [2:0]  reg_sel = 3'h0;
    logic [1:0]  reg_kind = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [55:0] pin_i, pin_o, pin_oe, la_in_bus, addr_flags;
    logic [55:0] ext_oe = 56'h0, ext_val = 56'h0, la_out = 56'h0;
    logic [55:0] cfg_la_out = 56'h0, cfg_la_in = 56'h0, la_pt = 56'h0;
    logic [55:0] cfg_latch = 56'h0;
    logic [55:0] cfg_dec = 56'hffffffffffffff;
    logic [15:0] addr = 16'h0, bus_rdata = 16'h0, pattern = 16'h0, fg_in;
    logic        nonmux = 1'h0, burst = 1'h0, rstpat = 1'h0, fam16 = 1'h0;
    logic        strobe = 1'h0, host_rst = 1'h0, bus_rd = 1'h0;
    logic        bus_wr = 1'h0, psel_a = 1'h0, psel_b = 1'h0;
    logic        jtag = 1'h0, tp_out = 1'h0;
    logic [7:0]  peri = 8'h00;
    logic [2:0]  tp_in;
    int          n_fail = 0;
    int          tests_run = 0;

    always #12.5 clk = ~clk;

    iopm_port_mux DUT
    (
        .CORE_CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .REG_WR(reg_wr),
        .REG_SEL(reg_sel), .REG_KIND(reg_kind), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .PIN_I(pin_i), .PIN_O(pin_o),
        .PIN_OE(pin_oe), .CFG_LA_OUT(cfg_la_out), .CFG_LA_IN(cfg_la_in),
        .CFG_IN_LATCH(cfg_latch), .CFG_DECODE_USE(cfg_dec),
        .CFG_NONMUX(nonmux), .CFG_BURST(burst), .CFG_RSTPAT_EN(rstpat),
        .CFG_FAMILY16(fam16), .CFG_PATTERN(pattern),
        .LA_OUT_DATA(la_out), .LA_OE_PT(la_pt), .LA_IN_BUS(la_in_bus),
        .ADDR_IN_FLAGS(addr_flags), .ADDR_PINS(addr), .STROBE_PIN(strobe),
        .HOST_RESET_PIN(host_rst), .BUS_RD(bus_rd), .BUS_WR(bus_wr),
        .BUS_RDATA(bus_rdata), .PORT_FG_IN(fg_in), .PSEL_A(psel_a),
        .PSEL_B(psel_b), .PERI_WDATA(peri), .JTAG_EN(jtag),
        .TP_OUT(tp_out), .TP_IN(tp_in)
    );

    iopm_pin_model PINS
    (
        .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_i(pin_i)
    );

    // ***************
    // Host tasks
    // ***************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] s, input logic [1:0] k,
                      input logic [7:0] d);
        reg_wr = 1'h1;
        reg_sel = s;
        reg_kind = k;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'h0;
        // Idle edge so a following write never re-raises the strobe at once
        tick(1);
    endtask : wr

    task automatic rd(input logic [2:0] s, input logic [1:0] k,
                      input logic [7:0] e);
        reg_sel = s;
        reg_kind = k;
        tick(1);
        check(reg_rdata, e);
    endtask : rd

    task automatic do_reset;
        nrst = 1'h0;
        tick(4);
        nrst = 1'h1;
        tick(1);
    endtask : do_reset

    // Address latched by strobe, then enabled on E, F and G
    task automatic addr_out(input logic [15:0] a);
        addr = a;
        strobe = 1'h1;
        tick(4);
        strobe = 1'h0;
        for (int s = 4; s < 7; s++)
        begin
            wr(3'(s), iopm_pkg::KIND_CTRL, 8'hff);
            wr(3'(s), iopm_pkg::KIND_DIR, 8'hff);
        end
        tick(2);
    endtask : addr_out

    task automatic give_verdict;
        $display("TB counts: %0d mismatches, %0d comparisons",
                 n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // ***************
    // Scenarios
    // ***************
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    initial
    begin
        cfg_la_out[15:8] = 8'hff;
        cfg_la_in[3:0] = 4'hf;
        cfg_la_in[27:24] = 4'hf;
        cfg_latch[27:24] = 4'hf;
        do_reset();
        for (int s = 0; s < 7; s++)
        begin
            rd(3'(s), iopm_pkg::KIND_DIR, 8'h00);
            rd(3'(s), iopm_pkg::KIND_CTRL, 8'h00);
        end
        check(pin_oe, 56'h0);
        check(addr_flags, 56'h00ff000fffffff);
        wr(3'h2, iopm_pkg::KIND_DOUT, 8'ha5);
        wr(3'h2, iopm_pkg::KIND_DIR, 8'h0f);
        tick(2);
        check({pin_oe[23:16], pin_o[19:16]}, 12'h0f5);
        la_pt[23:16] = 8'hf0;
        la_pt[39:32] = 8'hff;
        tick(2);
        check({pin_oe[23:16], pin_o[23:16]}, 16'hffa5);
        check(pin_oe[39:32], 8'h00);
        la_pt = 56'h0;
        ext_oe[27:24] = 4'hf;
        ext_val[27:24] = 4'h9;
        tick(4);
        rd(3'h3, iopm_pkg::KIND_PIN, 8'h09);
        wr(3'h3, iopm_pkg::KIND_DOUT, 8'hff);
        rd(3'h3, iopm_pkg::KIND_DOUT, 8'h0f);
        wr(3'h1, iopm_pkg::KIND_CTRL, 8'hff);
        rd(3'h1, iopm_pkg::KIND_CTRL, 8'h00);
        la_out[15:8] = 8'h5a;
        la_pt[15:8] = 8'hff;
        tick(2);
        check({pin_oe[15:8], pin_o[15:8]}, 16'hff5a);
        // Config edits after reset must not reach the pins
        cfg_la_out[15:8] = 8'h00;
        tick(2);
        check(pin_o[15:8], 8'h5a);
        la_pt = 56'h0;
        tick(2);
        check(pin_oe[15:8], 8'h00);
        // Logic-input pins keep direction 0 throughout
        ext_oe[3:0] = 4'hf;
        ext_val[3:0] = 4'h6;
        tick(4);
        // Direct inputs follow, latched ones hold until a strobe
        check({la_in_bus[27:24], la_in_bus[3:0]}, 8'h06);
        addr = 16'h1234;
        strobe = 1'h1;
        tick(4);
        strobe = 1'h0;
        check(la_in_bus[27:24], 4'h9);
        wr(3'h4, iopm_pkg::KIND_CTRL, 8'hff);
        tick(2);
        check(pin_oe[39:32], 8'h00);
        // Address pins stay idle until the host enables them
        addr_out(16'h1234);
        check(pin_o[55:32], 24'h123434);
        check(pin_oe[55:32], 24'hffffff);
        wr(3'h4, iopm_pkg::KIND_DOUT, 8'hc3);
        wr(3'h4, iopm_pkg::KIND_CTRL, 8'h00);
        tick(2);
        check(pin_o[39:32], 8'hc3);
        for (int s = 4; s < 7; s++)
        begin
            wr(3'(s), iopm_pkg::KIND_CTRL, 8'h00);
            wr(3'(s), iopm_pkg::KIND_DIR, 8'h00);
        end
        jtag = 1'h1;
        tp_out = 1'h1;
        ext_oe[34:32] = 3'h7;
        ext_val[34:32] = 3'h5;
        tick(4);
        check({tp_in, pin_o[35]}, 4'hb);
        jtag = 1'h0;
        tick(4);
        check(tp_in, 3'h0);
        wr(3'h7, iopm_pkg::KIND_CTRL, 8'h80);
        rd(3'h7, iopm_pkg::KIND_CTRL, 8'h80);
        bus_wr = 1'h1;
        peri = 8'h3c;
        tick(2);
        check(pin_oe[47:40], 8'h00);
        psel_a = 1'h1;
        tick(2);
        check({pin_oe[47:40], pin_o[47:40]}, 16'hff3c);
        psel_a = 1'h0;
        psel_b = 1'h1;
        tick(2);
        check({pin_oe[47:40], pin_o[47:40]}, 16'hff3c);
        wr(3'h7, iopm_pkg::KIND_CTRL, 8'h00);
        tick(2);
        check(pin_oe[47:40], 8'h00);
        bus_wr = 1'h0;
        psel_b = 1'h0;
        burst = 1'h1;
        do_reset();
        addr_out(16'hbeef);
        // Low nibbles keep host data; direction alone enables them
        check(pin_oe[55:32], 24'hffffff);
        check({pin_o[43:40], pin_o[35:32]}, 8'h00);
        check({pin_o[55:44], pin_o[39:36]}, 16'hbeee);
        burst = 1'h0;
        nonmux = 1'h1;
        rstpat = 1'h1;
        fam16 = 1'h1;
        pattern = 16'h5aa5;
        host_rst = 1'h1;
        do_reset();
        tick(4);
        check({pin_oe[55:40], pin_o[55:40]}, 32'hffff5aa5);
        host_rst = 1'h0;
        bus_rd = 1'h1;
        bus_rdata = 16'h1234;
        tick(4);
        check(pin_o[55:40], 16'h1234);
        bus_rd = 1'h0;
        ext_oe[55:40] = 16'hffff;
        ext_val[55:40] = 16'habcd;
        tick(4);
        check(fg_in, 16'habcd);
        fam16 = 1'h0;
        host_rst = 1'h1;
        do_reset();
        tick(4);
        check(pin_oe[55:40], 16'h0);
        give_verdict();
    end
endmodule : iopm_port_mux_bench
